// ---- hdl/esrc_pkg.sv ----
// constants for the controller of an asynchronous 512k x 32 error-correcting memory
// assumes a 10 MHz system clock; all device timing is rounded to whole cycles
package esrc_pkg;
  localparam int ADDR_W = 19;
  localparam int DATA_W = 32;
  localparam int CLK_PERIOD_PS = 100000;
  // device timing figures in picoseconds
  localparam int T_READ_CYCLE_PS = 20000;
  localparam int T_GLQV_PS = 8600;
  localparam int T_FLOAT_PS = 5000;
  localparam int T_WRITE_PULSE_PS = 12000;
  localparam int T_FLAG_LOW_PS = 5000;
  // least times round up, never below one cycle
  function automatic int cyc_up(input int ps);
    int c;
    c = (ps + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    return (c < 1) ? 1 : c;
  endfunction : cyc_up
  localparam int READ_CYC = cyc_up(T_READ_CYCLE_PS);
  localparam int GLQV_CYC = cyc_up(T_GLQV_PS);
  localparam int FLOAT_CYC = cyc_up(T_FLOAT_PS);
  localparam int WRITE_CYC = cyc_up(T_WRITE_PULSE_PS);
  localparam int FLAG_LOW_CYC = cyc_up(T_FLAG_LOW_PS);
  localparam int CNT_W = 4;
  localparam logic [ADDR_W-1:0] ADDR_RESET = 19'h00000;
  localparam logic [DATA_W-1:0] DATA_RESET = 32'h00000000;
  typedef enum logic [1:0] {
    ESRC_CMD_READ,
    ESRC_CMD_WRITE,
    ESRC_CMD_STANDBY
  } esrc_cmd_type;
endpackage : esrc_pkg

// ---- hdl/esrc_sync_if.sv ----
// carries the synchronised device input levels between the controller modules
// assumes a single clock domain
`timescale 1ns/10ps
`default_nettype none
interface esrc_sync_if;
  logic [esrc_pkg::DATA_W-1:0] data;
  logic flag;
  modport src (output data, output flag);
  modport dst (input data, input flag);
endinterface : esrc_sync_if
`default_nettype wire

// ---- hdl/esrc_sync.sv ----
// two-stage synchroniser for the data bus and error flag pin levels
// assumes the pins are asynchronous to sys_clk
`timescale 1ns/10ps
`default_nettype none
module esrc_sync (
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst_n,
  // raw pins
  input wire logic [esrc_pkg::DATA_W-1:0] data_pin,
  input wire logic flag_pin,
  // synchronised levels
  esrc_sync_if.src sync
);
  logic [esrc_pkg::DATA_W-1:0] data_meta_reg;
  logic flag_meta_reg;
  // first stage feeds only the second stage
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      data_meta_reg <= esrc_pkg::DATA_RESET;
      flag_meta_reg <= 1'b0;
      sync.data <= esrc_pkg::DATA_RESET;
      sync.flag <= 1'b0;
    end else begin
      data_meta_reg <= data_pin;
      flag_meta_reg <= flag_pin;
      sync.data <= data_meta_reg;
      sync.flag <= flag_meta_reg;
    end
  end
endmodule : esrc_sync
`default_nettype wire

// ---- hdl/esrc_ctrl.sv ----
// controller that drives an asynchronous error-correcting 512k x 32 memory
// assumes an external pull-down on the error flag pin and one user on the command port
// Contract
// - read: selected, write strobe high, drive low
// - drive and strobe high: flag pin low
// - clear: deselect first, then raise drive
// - wait flag low, move to good address
// - address changes no faster than 20 ns
`timescale 1ns/10ps
`default_nettype none
module esrc_ctrl #(
  parameter int ADDR_W = esrc_pkg::ADDR_W,
  parameter int DATA_W = esrc_pkg::DATA_W
) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst_n,
  // user command port
  input wire logic cmd_valid,
  input wire esrc_pkg::esrc_cmd_type cmd_op,
  input wire logic [ADDR_W-1:0] cmd_addr,
  input wire logic [DATA_W-1:0] cmd_wdata,
  input wire logic [ADDR_W-1:0] safe_addr,
  input wire logic scrub_in_standby,
  output logic cmd_ready,
  output logic rsp_valid,
  output logic [DATA_W-1:0] rsp_rdata,
  output logic rsp_error,
  output logic flag_cleared,
  // memory pins
  output logic chip_select_first_n,
  output logic chip_select_second,
  output logic write_strobe_n,
  output logic output_drive_n,
  output logic [ADDR_W-1:0] mem_addr,
  input wire logic [DATA_W-1:0] data_in,
  output logic [DATA_W-1:0] data_out,
  output logic data_oe,
  input wire logic error_flag_pin_in,
  output logic error_flag_pin_out,
  output logic error_flag_pin_oe
);
  // ************************************************************
  // synchronised pins
  // ************************************************************
  esrc_sync_if sync_bus ();
  esrc_sync u_sync (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .data_pin(data_in),
    .flag_pin(error_flag_pin_in),
    .sync(sync_bus.src)
  );
  // ************************************************************
  // sequencer
  // ************************************************************
  typedef enum logic [3:0] {
    ST_IDLE, ST_READ, ST_WRITE, ST_FLOAT,
    ST_DESELECT, ST_DRIVE_HIGH, ST_WAIT_LOW, ST_RESELECT, ST_CLEAR_READ
  } esrc_state_type;
  esrc_state_type state_reg;
  logic [esrc_pkg::CNT_W-1:0] cnt_reg;
  logic cnt_done;
  logic flag_seen_reg;
  assign cnt_done = (cnt_reg == '0);
  function automatic logic [esrc_pkg::CNT_W-1:0] cyc(input int n);
    return esrc_pkg::CNT_W'(n - 1);
  endfunction : cyc
  // state and wait counter; every wait is at least the device figure
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_reg <= ST_IDLE;
      cnt_reg <= '0;
    end else begin
      if (!cnt_done) begin
        cnt_reg <= cnt_reg - 1'b1;
      end
      unique case (state_reg)
        ST_IDLE: begin
          if (cmd_valid && cmd_op == esrc_pkg::ESRC_CMD_READ) begin
            state_reg <= ST_READ;
            cnt_reg <= cyc(esrc_pkg::READ_CYC + 2);
          end else if (cmd_valid && cmd_op == esrc_pkg::ESRC_CMD_WRITE) begin
            state_reg <= ST_WRITE;
            cnt_reg <= cyc(esrc_pkg::WRITE_CYC);
          end
        end
        ST_READ: begin
          // two extra cycles cover the synchroniser on sampled data
          if (cnt_done) begin
            state_reg <= ST_FLOAT;
            cnt_reg <= cyc(esrc_pkg::FLOAT_CYC);
          end
        end
        ST_WRITE: begin
          if (cnt_done) begin
            state_reg <= ST_FLOAT;
            cnt_reg <= cyc(esrc_pkg::FLOAT_CYC);
          end
        end
        ST_FLOAT: begin
          // bus floats before anything else drives it
          if (cnt_done) begin
            state_reg <= flag_seen_reg ? ST_DESELECT : ST_IDLE;
            cnt_reg <= cyc(esrc_pkg::FLOAT_CYC);
          end
        end
        ST_DESELECT: begin
          if (cnt_done) begin
            state_reg <= ST_DRIVE_HIGH;
            cnt_reg <= cyc(esrc_pkg::FLAG_LOW_CYC);
          end
        end
        ST_DRIVE_HIGH: begin
          if (cnt_done) begin
            state_reg <= ST_WAIT_LOW;
          end
        end
        ST_WAIT_LOW: begin
          if (!sync_bus.flag) begin
            state_reg <= ST_RESELECT;
            cnt_reg <= cyc(esrc_pkg::READ_CYC + 1);
          end
        end
        ST_RESELECT: begin
          if (cnt_done) begin
            state_reg <= ST_CLEAR_READ;
            cnt_reg <= cyc(esrc_pkg::GLQV_CYC + 2);
          end
        end
        ST_CLEAR_READ: begin
          if (cnt_done) begin
            state_reg <= ST_FLOAT;
            cnt_reg <= cyc(esrc_pkg::FLOAT_CYC);
          end
        end
      endcase
    end
  end
  // ************************************************************
  // pin drive
  // ************************************************************
  // pins registered so every output comes from a flip-flop
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      chip_select_first_n <= 1'b1;
      chip_select_second <= 1'b0;
      write_strobe_n <= 1'b1;
      output_drive_n <= 1'b1;
      mem_addr <= esrc_pkg::ADDR_RESET;
      data_out <= esrc_pkg::DATA_RESET;
      data_oe <= 1'b0;
    end else begin
      unique case (state_reg)
        ST_IDLE: begin
          write_strobe_n <= 1'b1;
          output_drive_n <= 1'b1;
          data_oe <= 1'b0;
          if (cmd_valid && cmd_op != esrc_pkg::ESRC_CMD_STANDBY) begin
            chip_select_first_n <= 1'b0;
            chip_select_second <= 1'b1;
            mem_addr <= cmd_addr; // one access per read cycle time
            data_out <= cmd_wdata;
            output_drive_n <= (cmd_op == esrc_pkg::ESRC_CMD_READ) ? 1'b0 : 1'b1;
            write_strobe_n <= (cmd_op == esrc_pkg::ESRC_CMD_WRITE) ? 1'b0 : 1'b1;
            data_oe <= (cmd_op == esrc_pkg::ESRC_CMD_WRITE); // data bus driven only for writes
          end else begin
            // scrub standby uses second select low; otherwise first select high
            chip_select_first_n <= !scrub_in_standby;
            chip_select_second <= 1'b0;
          end
        end
        ST_WRITE: begin
          if (cnt_done) begin
            write_strobe_n <= 1'b1;
          end
        end
        ST_READ, ST_CLEAR_READ: begin
          // on an error the device is deselected first; drive rises a cycle later
          if (cnt_done && sync_bus.flag) begin
            chip_select_first_n <= 1'b1;
            chip_select_second <= 1'b0;
          end else if (cnt_done) begin
            output_drive_n <= 1'b1;
          end
        end
        ST_FLOAT: begin
          data_oe <= 1'b0;
          output_drive_n <= 1'b1;
          write_strobe_n <= 1'b1;
        end
        ST_DESELECT: begin
          chip_select_first_n <= 1'b1; // scrub pauses here
          chip_select_second <= 1'b0;
        end
        ST_DRIVE_HIGH, ST_WAIT_LOW: begin
          output_drive_n <= 1'b1;
          mem_addr <= safe_addr;
        end
        ST_RESELECT: begin
          chip_select_first_n <= 1'b0;
          chip_select_second <= 1'b1;
          if (cnt_done) begin
            output_drive_n <= 1'b0;
          end
        end
      endcase
    end
  end
  // ************************************************************
  // error flag pin: never driven high, so no function-select entry
  // ************************************************************
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      error_flag_pin_out <= 1'b0;
      error_flag_pin_oe <= 1'b0;
    end else begin
      error_flag_pin_out <= 1'b0;
      error_flag_pin_oe <= 1'b0;
    end
  end
  // ************************************************************
  // responses and flag tracking
  // ************************************************************
  // flag sample taken at end of access, flag high means error
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      rsp_valid <= 1'b0;
      rsp_rdata <= esrc_pkg::DATA_RESET;
      rsp_error <= 1'b0;
      flag_seen_reg <= 1'b0;
      flag_cleared <= 1'b0;
      cmd_ready <= 1'b0;
    end else begin
      rsp_valid <= 1'b0;
      flag_cleared <= 1'b0;
      cmd_ready <= (state_reg == ST_FLOAT) && cnt_done && !flag_seen_reg;
      if (state_reg == ST_READ && cnt_done) begin
        rsp_valid <= 1'b1;
        rsp_rdata <= sync_bus.data;
        rsp_error <= sync_bus.flag;
        flag_seen_reg <= sync_bus.flag;
      end
      if (state_reg == ST_CLEAR_READ && cnt_done) begin
        flag_seen_reg <= sync_bus.flag;
        flag_cleared <= !sync_bus.flag;
      end
    end
  end
endmodule : esrc_ctrl
`default_nettype wire

// ---- testbench/esrc_mem_model.sv ----
// behavioural model of the error-correcting memory seen by the controller
// assumes the bench resolves the bus and the pulled-down error pin
`timescale 1ns/10ps
`default_nettype none
module esrc_mem_model (
  // memory pins
  input wire logic sel1_n,
  input wire logic sel2,
  input wire logic wr_n,
  input wire logic drv_n,
  input wire logic [esrc_pkg::ADDR_W-1:0] addr,
  input wire logic [31:0] dq_in,
  // device drivers
  output logic [31:0] dq_out,
  output logic dq_oe,
  output logic flag_out,
  output logic flag_oe
);
  // ****
  // storage and flag
  // ****
  logic [31:0] mem [logic [18:0]];
  logic sticky = 1'b0;
  logic armed = 1'b0;
  wire sel = !sel1_n && sel2;
  wire rd = sel && wr_n && !drv_n;
  // drivers let go 4 ns after release, inside the float window
  assign #4 dq_oe = rd;
  assign #4 flag_oe = rd;
  assign flag_out = sticky;
  // word write taken as the strobe ends
  always @(posedge wr_n) if (sel) mem[addr] = dq_in;
  // unwritten words read as garbage and set the sticky flag
  always @(addr or rd) begin
    dq_out = mem.exists(addr) ? mem[addr] : ~{13'h0, addr};
    if (rd) begin
      if (!mem.exists(addr)) sticky = 1'b1;
      else if (armed) sticky = 1'b0;
      armed = 1'b0;
    end
  end
  // deselecting with the flag up arms the clearing read
  always @(sel) if (!sel && sticky) armed = 1'b1;
endmodule : esrc_mem_model
`default_nettype wire

// ---- testbench/esrc_ctrl_sva.sv ----
// pin protocol checker for esrc_ctrl
// assumes one clock domain, bound onto every esrc_ctrl
`timescale 1ns/10ps
`default_nettype none
module esrc_ctrl_sva #(
  parameter int ADDR_W = esrc_pkg::ADDR_W
) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst_n,
  // user side
  input wire logic [ADDR_W-1:0] safe_addr,
  input wire logic rsp_valid,
  // memory pins
  input wire logic chip_select_first_n,
  input wire logic chip_select_second,
  input wire logic write_strobe_n,
  input wire logic output_drive_n,
  input wire logic [ADDR_W-1:0] mem_addr,
  input wire logic data_oe,
  input wire logic error_flag_pin_in,
  input wire logic error_flag_pin_oe
);
  // ****
  // properties
  // ****
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  // selection one cycle back tells a fresh read from a recovery read
  logic sel_q;
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) sel_q <= 1'b0;
    else sel_q <= !chip_select_first_n && chip_select_second;
  end
  sequence s_read_start;
    $fell(output_drive_n) && !sel_q;
  endsequence
  sequence s_read_body;
    !output_drive_n [*3] ##1 ((output_drive_n || chip_select_first_n) && rsp_valid);
  endsequence
  property p_read_len;
    s_read_start |-> s_read_body;
  endproperty
  a_read_len: assert property (p_read_len) else $error("read length wrong");
  property p_drive_sel;
    !output_drive_n |-> write_strobe_n && !data_oe && ((!chip_select_first_n && chip_select_second)
      || $past(!chip_select_first_n && chip_select_second && !output_drive_n));
  endproperty
  a_drive_sel: assert property (p_drive_sel) else $error("drive outside read");
  property p_fn_sel;
    error_flag_pin_oe |-> !(write_strobe_n && output_drive_n);
  endproperty
  a_fn_sel: assert property (p_fn_sel) else $error("flag pin driven");
  property p_clear_order;
    $rose(output_drive_n) && $past(error_flag_pin_in) |-> chip_select_first_n || !chip_select_second;
  endproperty
  a_clear_order: assert property (p_clear_order) else $error("drive raised while selected");
  property p_reselect;
    $fell(chip_select_first_n) && chip_select_second && output_drive_n && write_strobe_n
      |-> mem_addr == safe_addr && !error_flag_pin_in;
  endproperty
  a_reselect: assert property (p_reselect) else $error("bad reselect");
  property p_addr_hold;
    !output_drive_n && !$past(output_drive_n) |-> $stable(mem_addr);
  endproperty
  a_addr_hold: assert property (p_addr_hold) else $error("address moved in read");
  property p_write_drive;
    !write_strobe_n |-> data_oe && output_drive_n && !chip_select_first_n && chip_select_second;
  endproperty
  a_write_drive: assert property (p_write_drive) else $error("write pins wrong");
endmodule : esrc_ctrl_sva
bind esrc_ctrl esrc_ctrl_sva #(.ADDR_W(ADDR_W)) i_esrc_ctrl_sva (.sys_clk(sys_clk),
  .rst_n(rst_n), .safe_addr(safe_addr), .rsp_valid(rsp_valid),
  .chip_select_first_n(chip_select_first_n), .chip_select_second(chip_select_second),
  .write_strobe_n(write_strobe_n), .output_drive_n(output_drive_n), .mem_addr(mem_addr),
  .data_oe(data_oe), .error_flag_pin_in(error_flag_pin_in),
  .error_flag_pin_oe(error_flag_pin_oe));
`default_nettype wire

// ---- testbench/testbench.sv ----
// self-checking bench: esrc_ctrl against a behavioural memory
// assumes design, model and checker are compiled first
`timescale 1ns/10ps
`default_nettype none
`define CHK(g, e) begin samples_checked++; if ((g) !== (e)) begin num_errors++; $display("CHECK FAILED t=%0t got=%0h exp=%0h", $time, g, e); end end
module testbench;
  // ****
  // signals
  // ****
  localparam esrc_pkg::esrc_cmd_type RD = esrc_pkg::ESRC_CMD_READ;
  localparam esrc_pkg::esrc_cmd_type WR = esrc_pkg::ESRC_CMD_WRITE;
  logic sys_clk = 1'b0;
  logic rst_n = 1'b0;
  logic cmd_valid = 1'b0;
  esrc_pkg::esrc_cmd_type cmd_op = RD;
  logic [18:0] cmd_addr = 19'h00000;
  logic [18:0] safe_addr = 19'h00010;
  logic [18:0] ra;
  logic [18:0] mem_addr;
  logic [31:0] cmd_wdata = 32'h00000000;
  logic [31:0] float_pat = 32'h00000000;
  logic [31:0] seed = 32'h97AC39FC;
  logic [31:0] rsp_rdata, data_out, data_in, dq_out;
  logic scrub_in_standby = 1'b0;
  logic cmd_ready, rsp_valid, rsp_error, flag_cleared, cs1_n, cs2, wr_n, od_n, data_oe;
  logic fl_out, fl_oe, dq_oe, flag_out, flag_oe, flag_pin;
  logic [31:0] ref_mem [logic [18:0]];
  int num_errors = 0;
  int samples_checked = 0;
  initial begin
    forever #50 sys_clk = ~sys_clk;
  end
  // a released bus walks, so a stale value never reads back by luck
  always @(posedge sys_clk) float_pat <= {float_pat[30:0], ~float_pat[31]};
  assign data_in = data_oe ? data_out : (dq_oe ? dq_out : float_pat);
  assign flag_pin = flag_oe ? flag_out : (fl_oe ? fl_out : 1'b0);
  esrc_ctrl i_esrc_ctrl (.sys_clk(sys_clk), .rst_n(rst_n), .cmd_valid(cmd_valid),
    .cmd_op(cmd_op), .cmd_addr(cmd_addr), .cmd_wdata(cmd_wdata), .safe_addr(safe_addr),
    .scrub_in_standby(scrub_in_standby), .cmd_ready(cmd_ready), .rsp_valid(rsp_valid),
    .rsp_rdata(rsp_rdata), .rsp_error(rsp_error), .flag_cleared(flag_cleared),
    .chip_select_first_n(cs1_n), .chip_select_second(cs2), .write_strobe_n(wr_n),
    .output_drive_n(od_n), .mem_addr(mem_addr), .data_in(data_in), .data_out(data_out),
    .data_oe(data_oe), .error_flag_pin_in(flag_pin), .error_flag_pin_out(fl_out),
    .error_flag_pin_oe(fl_oe));
  esrc_mem_model i_esrc_mem_model (.sel1_n(cs1_n), .sel2(cs2), .wr_n(wr_n), .drv_n(od_n),
    .addr(mem_addr), .dq_in(data_in), .dq_out(dq_out), .dq_oe(dq_oe), .flag_out(flag_out),
    .flag_oe(flag_oe));
  // ****
  // helpers
  // ****
  function automatic logic [31:0] xs(input logic [31:0] s);
    s ^= s << 13;
    s ^= s >> 17;
    s ^= s << 5;
    return s;
  endfunction : xs
  function automatic logic exp_err(input logic [18:0] a);
    return !ref_mem.exists(a);
  endfunction : exp_err
  task automatic report_and_stop();
    $display("errors %0d checks %0d", num_errors, samples_checked);
    if (num_errors == 0 && samples_checked > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : report_and_stop
  // one command, then wait for idle; standby is waited out, then its select levels are checked
  task automatic run(input esrc_pkg::esrc_cmd_type op, input logic [18:0] a,
    input logic [31:0] d);
    int n;
    @(negedge sys_clk);
    seed = xs(seed);
    scrub_in_standby = seed[0];
    cmd_valid = 1'b1;
    cmd_op = op;
    cmd_addr = a;
    cmd_wdata = d;
    @(negedge sys_clk);
    cmd_valid = 1'b0;
    n = 0;
    while (cmd_ready !== 1'b1 && flag_cleared !== 1'b1 && n < 60) begin
      @(negedge sys_clk);
      n++;
    end
    `CHK(fl_oe, 1'b0)
    if (op != esrc_pkg::ESRC_CMD_STANDBY) `CHK(n < 60, 1'b1)
    else `CHK({cs1_n, cs2}, {!scrub_in_standby, 1'b0})
    if (op == WR) begin
      ref_mem[a] = d;
      `CHK(cmd_ready, 1'b1)
    end
    if (op == RD) begin
      `CHK(rsp_error, exp_err(a))
      `CHK(flag_cleared, exp_err(a))
      if (!exp_err(a)) `CHK(rsp_rdata, ref_mem[a])
    end
  endtask : run
  // ****
  // sequence
  // ****
  initial begin
    #500000;
    num_errors++;
    report_and_stop();
  end
  initial begin
    repeat (20) @(negedge sys_clk);
    rst_n = 1'b1;
    run(WR, safe_addr, 32'hA5A5A5A5);
    run(WR, 19'h7FFFF, 32'hFFFFFFFF);
    run(RD, 19'h7FFFF, 32'h00000000);
    run(WR, 19'h00000, 32'h00000000);
    run(RD, 19'h00000, 32'h00000000);
    for (int i = 0; i < 16; i++) begin
      seed = xs(seed);
      ra = seed[18:0];
      seed = xs(seed);
      run(WR, ra, seed);
      run(RD, ra, 32'h00000000);
    end
    run(RD, 19'h55555, 32'h00000000);
    run(RD, safe_addr, 32'h00000000);
    run(esrc_pkg::ESRC_CMD_STANDBY, 19'h00000, 32'h00000000);
    run(RD, 19'h7FFFF, 32'h00000000);
    report_and_stop();
  end
endmodule : testbench
`default_nettype wire
